// ===== verilog/slc_regs_top.sv
`timescale 1ns/100ps
`default_nettype none
module slc_regs_top
(
    input  wire logic       clk_sys_in,            // System clock, 40 MHz
    input  wire logic       rstn_in,               // Async reset, active low
    input  wire logic       spi_sen_n_in,          // Serial frame enable, active low
    input  wire logic       spi_sclk_in,           // Serial clock
    input  wire logic       spi_sdi_in,            // Serial data in
    output logic            spi_sdo_out,           // Serial data out
    output logic            spi_sdo_oe_out,        // Serial data out drive enable
    input  wire logic       timing_ref_pin_in,     // Timing reference from pins
    input  wire logic       sync_n_pin_in,         // Sync request pin
    output logic            timing_ref_out,        // Internal timing reference
    output logic            sync_n_out,            // Sync after polarity
    output logic            timing_ref_delay_on_out, // Delay path active
    output logic [2:0]      timing_ref_delay_step_out, // Delay step 1..6, 0 none
    output logic [8:0]      timing_ref_delay_ps_out,   // Nominal total delay, ps
    output logic [2:0]      lane_amplitude_code_out,   // Lane swing code
    output logic [9:0]      lane_amplitude_mv_out,     // Lane swing, mVpp
    output logic            low_rate_enable_first_out, // First low-rate enable
    output logic            low_rate_enable_second_out // Second low-rate enable
);
    import slc_pkg::*;

    slc_bus_if bus ();

    slc_spi_slave slc_spi_slave_inst
    (
        .clk_sys_in     (clk_sys_in),
        .rstn_in        (rstn_in),
        .spi_sen_n_in   (spi_sen_n_in),
        .spi_sclk_in    (spi_sclk_in),
        .spi_sdi_in     (spi_sdi_in),
        .spi_sdo_out    (spi_sdo_out),
        .spi_sdo_oe_out (spi_sdo_oe_out),
        .bus            (bus)
    );

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    wire wr_dly_ctrl = bus.wr_en && (bus.addr == SLC_OFS_SYSREF_DELAY_CTRL);
    wire wr_swing    = bus.wr_en && (bus.addr == SLC_OFS_SERDES_SWING_CTRL);
    wire wr_lr_a     = bus.wr_en && (bus.addr == SLC_OFS_ADC_LOW_RATE_A);
    wire wr_lr_b     = bus.wr_en && (bus.addr == SLC_OFS_ADC_LOW_RATE_B);
    wire wr_src      = bus.wr_en && (bus.addr == SLC_OFS_SYSREF_REG_SOURCE);
    wire wr_pol      = bus.wr_en && (bus.addr == SLC_OFS_SYNC_POLARITY);
    wire wr_fine     = bus.wr_en && (bus.addr == SLC_OFS_SYSREF_DELAY_FINE);

    ////////////////////////////////////////////////////////////////////////
    // Register fields; only field bits are stored
    logic       delay_en_ff;
    logic [1:0] delay_high_ff;
    logic [2:0] delay_low_ff;
    logic [2:0] swing_ff;
    logic       low_rate_1_ff;
    logic       low_rate_2_ff;
    logic       source_sel_ff;
    logic       level_ff;
    logic       sync_inv_ff;

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            delay_en_ff   <= SLC_RST_BIT;
            delay_high_ff <= SLC_RST_HIGH;
            delay_low_ff  <= SLC_RST_LOW;
            swing_ff      <= SLC_RST_SWNG;
            low_rate_1_ff <= SLC_RST_BIT;
            low_rate_2_ff <= SLC_RST_BIT;
            source_sel_ff <= SLC_RST_BIT;
            level_ff      <= SLC_RST_BIT;
            sync_inv_ff   <= SLC_RST_BIT;
        end
        else
        begin
            // Reserved positions of the write data are dropped
            if (wr_dly_ctrl)
            begin
                delay_en_ff   <= bus.wdata[SLC_BIT_DELAY_EN];
                delay_high_ff <= bus.wdata[SLC_LSB_DELAY_HIGH +: 2];
            end
            if (wr_fine)
                delay_low_ff <= bus.wdata[SLC_LSB_DELAY_LOW +: 3];
            if (wr_swing)
                swing_ff <= bus.wdata[SLC_LSB_SWING +: 3];
            if (wr_lr_a)
                low_rate_1_ff <= bus.wdata[SLC_BIT_LOW_RATE_1];
            if (wr_lr_b)
                low_rate_2_ff <= bus.wdata[SLC_BIT_LOW_RATE_2];
            if (wr_src)
            begin
                source_sel_ff <= bus.wdata[SLC_BIT_SOURCE_SELECT];
                level_ff      <= bus.wdata[SLC_BIT_LEVEL];
            end
            if (wr_pol)
                sync_inv_ff <= bus.wdata[SLC_BIT_SYNC_INVERT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read back; reserved bits and unmapped addresses read zero
    logic [7:0] rd_mux;

    always_comb
    begin
        rd_mux = 8'h00;
        case (bus.addr)
            SLC_OFS_SYSREF_DELAY_CTRL:
            begin
                rd_mux[SLC_BIT_DELAY_EN]          = delay_en_ff;
                rd_mux[SLC_LSB_DELAY_HIGH +: 2]   = delay_high_ff;
            end
            SLC_OFS_SYSREF_DELAY_FINE:
                rd_mux[SLC_LSB_DELAY_LOW +: 3]    = delay_low_ff;
            SLC_OFS_SERDES_SWING_CTRL:
                rd_mux[SLC_LSB_SWING +: 3]        = swing_ff;
            SLC_OFS_ADC_LOW_RATE_A:
                rd_mux[SLC_BIT_LOW_RATE_1]        = low_rate_1_ff;
            SLC_OFS_ADC_LOW_RATE_B:
                rd_mux[SLC_BIT_LOW_RATE_2]        = low_rate_2_ff;
            SLC_OFS_SYSREF_REG_SOURCE:
            begin
                rd_mux[SLC_BIT_SOURCE_SELECT]     = source_sel_ff;
                rd_mux[SLC_BIT_LEVEL]             = level_ff;
            end
            SLC_OFS_SYNC_POLARITY:
                rd_mux[SLC_BIT_SYNC_INVERT]       = sync_inv_ff;
            default:
                rd_mux = 8'h00;
        endcase
    end

    assign bus.rdata = rd_mux;

    ////////////////////////////////////////////////////////////////////////
    // Delay decode; unlisted codes give no delay rather than a guess
    wire [4:0] delay_code = {delay_high_ff, delay_low_ff};
    logic [2:0] nxt_step;

    always_comb
    begin
        nxt_step = 3'h0;
        case (delay_code)
            SLC_DLY_CODE_1: nxt_step = 3'h1;
            SLC_DLY_CODE_2: nxt_step = 3'h2;
            SLC_DLY_CODE_3: nxt_step = 3'h3;
            SLC_DLY_CODE_4: nxt_step = 3'h4;
            SLC_DLY_CODE_5: nxt_step = 3'h5;
            SLC_DLY_CODE_6: nxt_step = 3'h6;
            default:        nxt_step = 3'h0;
        endcase
        if (!delay_en_ff)
            nxt_step = 3'h0;
    end

    // First step 175 ps, each further step 25 ps
    wire [8:0] step_ext  = {6'h00, nxt_step};
    wire [8:0] nxt_delay_ps = (nxt_step == 3'h0) ? 9'h000 :
        9'(SLC_DLY_FIRST_PS + 9'(SLC_DLY_STEP_PS * 9'(step_ext - 9'h001)));

    ////////////////////////////////////////////////////////////////////////
    // Swing decode
    logic [9:0] nxt_mv;

    always_comb
    begin
        nxt_mv = SLC_SWING_MV_0;
        case (swing_ff)
            3'h0:    nxt_mv = SLC_SWING_MV_0;
            3'h1:    nxt_mv = SLC_SWING_MV_1;
            3'h2:    nxt_mv = SLC_SWING_MV_2;
            3'h3:    nxt_mv = SLC_SWING_MV_3;
            3'h4:    nxt_mv = SLC_SWING_MV_4;
            3'h5:    nxt_mv = SLC_SWING_MV_5;
            3'h6:    nxt_mv = SLC_SWING_MV_6;
            3'h7:    nxt_mv = SLC_SWING_MV_7;
            default: nxt_mv = SLC_SWING_MV_0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; stage 1 feeds stage 2 only
    logic [1:0] ref_sync_ff;
    logic [1:0] syncn_sync_ff;

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ref_sync_ff   <= 2'h0;
            syncn_sync_ff <= 2'h3;
        end
        else
        begin
            ref_sync_ff   <= {ref_sync_ff[0], timing_ref_pin_in};
            syncn_sync_ff <= {syncn_sync_ff[0], sync_n_pin_in};
        end
    end

    // Level bit only reaches the output while register sourcing is on
    wire nxt_ref    = source_sel_ff ? level_ff : ref_sync_ff[1];
    wire nxt_sync_n = syncn_sync_ff[1] ^ sync_inv_ff;

    ////////////////////////////////////////////////////////////////////////
    // Output flops
    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            timing_ref_out            <= 1'b0;
            sync_n_out                <= 1'b1;
            timing_ref_delay_on_out   <= 1'b0;
            timing_ref_delay_step_out <= 3'h0;
            timing_ref_delay_ps_out   <= 9'h000;
            lane_amplitude_code_out   <= 3'h0;
            lane_amplitude_mv_out     <= SLC_SWING_MV_0;
        end
        else
        begin
            timing_ref_out            <= nxt_ref;
            sync_n_out                <= nxt_sync_n;
            timing_ref_delay_on_out   <= delay_en_ff;
            timing_ref_delay_step_out <= nxt_step;
            timing_ref_delay_ps_out   <= nxt_delay_ps;
            lane_amplitude_code_out   <= swing_ff;
            lane_amplitude_mv_out     <= nxt_mv;
        end
    end

    assign low_rate_enable_first_out  = low_rate_1_ff;
    assign low_rate_enable_second_out = low_rate_2_ff;
endmodule // slc_regs_top
`default_nettype wire

// ===== verilog/slc_pkg.sv
`default_nettype none
package slc_pkg;
    // Serial frame layout, MSB first
    localparam int unsigned SLC_ADDR_W      = 12;
    localparam int unsigned SLC_DATA_W      = 8;
    localparam int unsigned SLC_FRAME_BITS  = 24;
    localparam int unsigned SLC_HDR_BITS    = 16;
    localparam logic [4:0]  SLC_CNT_HDR     = 5'h10;
    localparam logic [4:0]  SLC_CNT_FRAME   = 5'h18;

    // Register offsets
    localparam logic [11:0] SLC_OFS_SYSREF_DELAY_CTRL = 12'h03c;
    localparam logic [11:0] SLC_OFS_SERDES_SWING_CTRL = 12'h03d;
    localparam logic [11:0] SLC_OFS_ADC_LOW_RATE_A    = 12'h03f;
    localparam logic [11:0] SLC_OFS_ADC_LOW_RATE_B    = 12'h042;
    localparam logic [11:0] SLC_OFS_SYSREF_REG_SOURCE = 12'h057;
    localparam logic [11:0] SLC_OFS_SYNC_POLARITY     = 12'h058;
    localparam logic [11:0] SLC_OFS_SYSREF_DELAY_FINE = 12'h05a;

    // Field positions
    localparam int unsigned SLC_BIT_DELAY_EN      = 6;
    localparam int unsigned SLC_LSB_DELAY_HIGH    = 0;
    localparam int unsigned SLC_LSB_DELAY_LOW     = 5;
    localparam int unsigned SLC_LSB_SWING         = 0;
    localparam int unsigned SLC_BIT_SOURCE_SELECT = 3;
    localparam int unsigned SLC_BIT_LEVEL         = 4;
    localparam int unsigned SLC_BIT_SYNC_INVERT   = 5;
    localparam int unsigned SLC_BIT_LOW_RATE_1    = 2;
    localparam int unsigned SLC_BIT_LOW_RATE_2    = 4;

    // Values after reset
    localparam logic       SLC_RST_BIT  = 1'b0;
    localparam logic [1:0] SLC_RST_HIGH = 2'h0;
    localparam logic [2:0] SLC_RST_LOW  = 3'h0;
    localparam logic [2:0] SLC_RST_SWNG = 3'h0;

    // Delay codes and their nominal totals in ps
    localparam logic [4:0] SLC_DLY_CODE_1 = 5'h08;
    localparam logic [4:0] SLC_DLY_CODE_2 = 5'h07;
    localparam logic [4:0] SLC_DLY_CODE_3 = 5'h06;
    localparam logic [4:0] SLC_DLY_CODE_4 = 5'h05;
    localparam logic [4:0] SLC_DLY_CODE_5 = 5'h04;
    localparam logic [4:0] SLC_DLY_CODE_6 = 5'h03;
    localparam logic [8:0] SLC_DLY_FIRST_PS = 9'd175;
    localparam logic [8:0] SLC_DLY_STEP_PS  = 9'd25;

    // Lane amplitude per swing code, mVpp
    localparam logic [9:0] SLC_SWING_MV_0 = 10'd860;
    localparam logic [9:0] SLC_SWING_MV_1 = 10'd810;
    localparam logic [9:0] SLC_SWING_MV_2 = 10'd770;
    localparam logic [9:0] SLC_SWING_MV_3 = 10'd745;
    localparam logic [9:0] SLC_SWING_MV_4 = 10'd960;
    localparam logic [9:0] SLC_SWING_MV_5 = 10'd930;
    localparam logic [9:0] SLC_SWING_MV_6 = 10'd905;
    localparam logic [9:0] SLC_SWING_MV_7 = 10'd880;
endpackage
`default_nettype wire

// ===== verilog/slc_bus_if.sv
`timescale 1ns/100ps
`default_nettype none
interface slc_bus_if;
    import slc_pkg::*;
    logic                  wr_en;
    logic [SLC_ADDR_W-1:0] addr;
    logic [SLC_DATA_W-1:0] wdata;
    logic [SLC_DATA_W-1:0] rdata;
    modport port_side (output wr_en, output addr, output wdata, input rdata);
    modport regs_side (input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ===== verilog/slc_spi_slave.sv
`timescale 1ns/100ps
`default_nettype none
module slc_spi_slave
(
    input  wire logic      clk_sys_in,     // System clock
    input  wire logic      rstn_in,        // Async reset, active low
    input  wire logic      spi_sen_n_in,   // Frame enable pin, active low
    input  wire logic      spi_sclk_in,    // Serial clock pin
    input  wire logic      spi_sdi_in,     // Serial data in pin
    output logic           spi_sdo_out,    // Serial data out
    output logic           spi_sdo_oe_out, // Drive enable for data out
    slc_bus_if.port_side   bus             // Register access
);
    import slc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers, third stage only for edge detect
    logic [1:0] sen_ff;
    logic [2:0] sclk_ff;
    logic [1:0] sdi_ff;

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            sen_ff  <= 2'h3;
            sclk_ff <= 3'h0;
            sdi_ff  <= 2'h0;
        end
        else
        begin
            sen_ff  <= {sen_ff[0], spi_sen_n_in};
            sclk_ff <= {sclk_ff[1:0], spi_sclk_in};
            sdi_ff  <= {sdi_ff[0], spi_sdi_in};
        end
    end

    wire frame_on  = !sen_ff[1];
    wire sclk_rise = frame_on && sclk_ff[1] && !sclk_ff[2];
    wire sclk_fall = frame_on && !sclk_ff[1] && sclk_ff[2];

    ////////////////////////////////////////////////////////////////////////
    logic [4:0]  cnt_ff;
    logic [22:0] shift_ff;
    logic [7:0]  rd_shift_ff;
    logic        rd_ff;
    logic        wr_ff;
    logic [SLC_ADDR_W-1:0] addr_ff;

    wire [4:0]  nxt_cnt   = cnt_ff + 5'h1;
    wire [23:0] frame_vec = {shift_ff, sdi_ff[1]};
    wire        hdr_done  = sclk_rise && (nxt_cnt == SLC_CNT_HDR);
    wire        frm_done  = sclk_rise && (nxt_cnt == SLC_CNT_FRAME);
    wire        in_data   = (cnt_ff > SLC_CNT_HDR) && (cnt_ff < SLC_CNT_FRAME);

    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            cnt_ff      <= 5'h0;
            shift_ff    <= 23'h0;
            rd_shift_ff <= 8'h00;
            rd_ff       <= 1'b0;
            wr_ff       <= 1'b0;
            addr_ff     <= {SLC_ADDR_W{1'b0}};
        end
        else
        begin
            wr_ff <= frm_done && !rd_ff;
            if (!frame_on)
            begin
                cnt_ff <= 5'h0;
                rd_ff  <= 1'b0;
            end
            else if (sclk_rise && (cnt_ff < SLC_CNT_FRAME))
            begin
                cnt_ff   <= nxt_cnt;
                shift_ff <= frame_vec[22:0];
            end
            if (hdr_done)
            begin
                rd_ff   <= shift_ff[14];
                addr_ff <= frame_vec[SLC_ADDR_W-1:0];
            end
            if (hdr_done && shift_ff[14])
                rd_shift_ff <= 8'h00;
            else if (cnt_ff == SLC_CNT_HDR && rd_ff && !sclk_rise && !sclk_fall)
                rd_shift_ff <= rd_shift_ff;
            if (sclk_fall && rd_ff && in_data)
                rd_shift_ff <= {rd_shift_ff[6:0], 1'b0};
            else if (rd_ff && cnt_ff == SLC_CNT_HDR)
                rd_shift_ff <= bus.rdata;
        end
    end

    assign bus.wr_en    = wr_ff;
    assign bus.addr     = addr_ff;
    assign bus.wdata    = shift_ff[7:0];
    assign spi_sdo_out    = rd_shift_ff[7];
    assign spi_sdo_oe_out = frame_on && rd_ff && (cnt_ff >= SLC_CNT_HDR);
endmodule // slc_spi_slave
`default_nettype wire

// ===== verilog/slc_spi_note.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ===== tb/slc_regs_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module slc_regs_asserts
(
    input wire logic       clk_sys_in,                 // Clock
    input wire logic       rstn_in,                    // Reset, active low
    input wire logic       spi_sen_n_in,               // Frame enable
    input wire logic       timing_ref_pin_in,          // Ref pin
    input wire logic       sync_n_pin_in,              // Sync pin
    input wire logic       timing_ref_out,             // Ref out
    input wire logic       sync_n_out,                 // Sync out
    input wire logic       timing_ref_delay_on_out,    // Delay on
    input wire logic [2:0] timing_ref_delay_step_out,  // Step
    input wire logic [8:0] timing_ref_delay_ps_out,    // Total ps
    input wire logic [2:0] lane_amplitude_code_out,    // Swing code
    input wire logic [9:0] lane_amplitude_mv_out,      // Swing mV
    input wire logic       low_rate_enable_first_out,  // Low rate 1
    input wire logic       low_rate_enable_second_out  // Low rate 2
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    ////////////////////////////////////////////////////////////////////////////
    // Idle time since last frame; writes land well inside twelve cycles
    logic [3:0] idle_ff;
    logic [3:0] nxt_idle;
    logic       quiet;
    assign nxt_idle = !spi_sen_n_in ? 4'h0 : (idle_ff == 4'hf) ? idle_ff : idle_ff + 4'h1;
    assign quiet    = idle_ff >= 4'hc;
    always_ff @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
            idle_ff <= 4'h0;
        else
            idle_ff <= nxt_idle;
    end
    function automatic logic [9:0] mv_of(input logic [2:0] c);
        logic [9:0] t [8];
        t = '{10'h35c, 10'h32a, 10'h302, 10'h2e9, 10'h3c0, 10'h3a2, 10'h389, 10'h370};
        return t[c];
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    a_delay_total: assert property (timing_ref_delay_ps_out == ((timing_ref_delay_step_out == 3'h0)
        ? 9'h000 : 9'h096 + 9'h019 * {6'h00, timing_ref_delay_step_out}))
        else $error("delay total does not match step");
    a_step_range: assert property (timing_ref_delay_step_out <= 3'h6)
        else $error("delay step out of range");
    a_step_needs_en: assert property (timing_ref_delay_step_out != 3'h0 |-> timing_ref_delay_on_out)
        else $error("delay step without enable");
    a_amp_table: assert property (lane_amplitude_mv_out == mv_of(lane_amplitude_code_out))
        else $error("lane amplitude does not match code");
    a_reset_zero: assert property ($rose(rstn_in) |-> !low_rate_enable_first_out
        && !low_rate_enable_second_out && timing_ref_delay_step_out == 3'h0
        && lane_amplitude_code_out == 3'h0 && !timing_ref_delay_on_out)
        else $error("field not zero after reset");
    a_cfg_quiet: assert property (quiet |-> $stable({low_rate_enable_first_out,
        low_rate_enable_second_out, lane_amplitude_code_out, timing_ref_delay_step_out}))
        else $error("config changed with no frame");
    a_sync_follow: assert property (quiet && $changed(sync_n_out)
        |-> $past(sync_n_pin_in, 3) != $past(sync_n_pin_in, 4))
        else $error("sync output moved without pin");
    a_ref_follow: assert property (quiet && $changed(timing_ref_out)
        |-> $past(timing_ref_pin_in, 3) != $past(timing_ref_pin_in, 4))
        else $error("timing ref moved without pin");
    c_step_last: cover property (timing_ref_delay_step_out == 3'h6);
    c_low_rate: cover property (low_rate_enable_second_out);
    c_ref_pin: cover property (quiet && $changed(timing_ref_out));
endmodule // slc_regs_asserts
`default_nettype wire

// ===== tb/slc_regs_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module slc_regs_top_tb;
    logic       clk_sys_in, rstn_in, spi_sen_n_in, spi_sclk_in, spi_sdi_in;
    logic       spi_sdo_out, spi_sdo_oe_out, timing_ref_pin_in, sync_n_pin_in;
    logic       timing_ref_out, sync_n_out, timing_ref_delay_on_out;
    logic [2:0] timing_ref_delay_step_out, lane_amplitude_code_out;
    logic [8:0] timing_ref_delay_ps_out;
    logic [9:0] lane_amplitude_mv_out;
    logic       low_rate_enable_first_out, low_rate_enable_second_out;
    int         num_errors = 0;
    int         compares = 0;
    int         cycles = 0;
    logic [11:0] regs [7] = '{12'h03c, 12'h03d, 12'h03f, 12'h042, 12'h057, 12'h058, 12'h05a};
    logic [15:0] mvt [8] = '{16'h35c, 16'h32a, 16'h302, 16'h2e9, 16'h3c0, 16'h3a2, 16'h389,
                             16'h370};
    slc_regs_top slc_regs_top_inst (.clk_sys_in, .rstn_in, .spi_sen_n_in, .spi_sclk_in,
        .spi_sdi_in, .spi_sdo_out, .spi_sdo_oe_out, .timing_ref_pin_in, .sync_n_pin_in,
        .timing_ref_out, .sync_n_out, .timing_ref_delay_on_out, .timing_ref_delay_step_out,
        .timing_ref_delay_ps_out, .lane_amplitude_code_out, .lane_amplitude_mv_out,
        .low_rate_enable_first_out, .low_rate_enable_second_out);
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    // Whole run is about 15k cycles
    always @(posedge clk_sys_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            num_errors = num_errors + 1;
            close_out();
        end
    end
    task automatic close_out();
        $display("Checks %0d, errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Serial clock half period of five cycles keeps above the sync limit
    task automatic xfer(input logic rd, input logic [11:0] a, input logic [7:0] wd,
                        output logic [7:0] q);
        logic [23:0] f;
        f = {rd, 3'h0, a, wd};
        spi_sen_n_in = 1'b0;
        tk(3);
        for (int i = 23; i >= 0; i--)
        begin
            spi_sdi_in = f[i];
            tk(5);
            if (i < 8)
                q[i] = spi_sdo_out;
            if (i < 8)
                chk("sdo_oe", {15'h0, rd}, {15'h0, spi_sdo_oe_out});
            spi_sclk_in = 1'b1;
            tk(5);
            spi_sclk_in = 1'b0;
        end
        tk(5);
        spi_sen_n_in = 1'b1;
        tk(12);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b0, a, d, q);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] e);
        logic [7:0] q;
        xfer(1'b1, a, 8'h00, q);
        chk("sdo_oe_idle", 16'h0, {15'h0, spi_sdo_oe_out});
        chk("rdata", {8'h0, e}, {8'h0, q});
    endtask
    task automatic chk_ref(input logic e);
        tk(5);
        chk("timing_ref", {15'h0, e}, {15'h0, timing_ref_out});
    endtask
    task automatic chk_sync(input logic e);
        tk(5);
        chk("sync_n", {15'h0, e}, {15'h0, sync_n_out});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("mv", 16'h35c, {6'h0, lane_amplitude_mv_out});
        chk("fields", 16'h0, {7'h0, low_rate_enable_first_out, low_rate_enable_second_out,
            timing_ref_delay_on_out, timing_ref_delay_step_out, lane_amplitude_code_out});
        foreach (regs[k])
            rdc(regs[k], 8'h00);
    endtask
    task automatic t_delay();
        logic [4:0] code;
        for (int s = 1; s <= 6; s++)
        begin
            code = 5'h09 - 5'(s);
            wr(12'h03c, {6'h10, code[4:3]});
            wr(12'h05a, {code[2:0], 5'h00});
            chk("step", 16'(s), {13'h0, timing_ref_delay_step_out});
            chk("ps", 16'(150 + 25 * s), {7'h0, timing_ref_delay_ps_out});
        end
        rdc(12'h05a, 8'h60);
        rdc(12'h03c, 8'h40);
        wr(12'h05a, 8'h1f);
        chk("step", 16'h0, {13'h0, timing_ref_delay_step_out});
        wr(12'h03c, 8'h01);
        chk("delay_on", 16'h0, {15'h0, timing_ref_delay_on_out});
        chk("step", 16'h0, {13'h0, timing_ref_delay_step_out});
    endtask
    task automatic t_swing();
        for (int c = 0; c < 8; c++)
        begin
            wr(12'h03d, 8'hf8 | 8'(c));
            chk("code", 16'(c), {13'h0, lane_amplitude_code_out});
            chk("mv", mvt[c], {6'h0, lane_amplitude_mv_out});
        end
        rdc(12'h03d, 8'h07);
    endtask
    task automatic t_source();
        timing_ref_pin_in = 1'b1;
        chk_ref(1'b1);
        wr(12'h057, 8'h08);
        chk_ref(1'b0);
        wr(12'h057, 8'h18);
        timing_ref_pin_in = 1'b0;
        chk_ref(1'b1);
        wr(12'h057, 8'h10);
        chk_ref(1'b0);
        wr(12'h057, 8'hff);
        rdc(12'h057, 8'h18);
        wr(12'h057, 8'h00);
    endtask
    task automatic t_sync();
        chk_sync(1'b1);
        wr(12'h058, 8'h20);
        chk_sync(1'b0);
        sync_n_pin_in = 1'b0;
        chk_sync(1'b1);
        wr(12'h058, 8'hdf);
        chk_sync(1'b0);
        rdc(12'h058, 8'h00);
        sync_n_pin_in = 1'b1;
    endtask
    task automatic t_low_rate();
        wr(12'h03f, 8'hff);
        chk("lr1", 16'h1, {15'h0, low_rate_enable_first_out});
        chk("lr2", 16'h0, {15'h0, low_rate_enable_second_out});
        rdc(12'h03f, 8'h04);
        wr(12'h042, 8'hff);
        chk("lr2", 16'h1, {15'h0, low_rate_enable_second_out});
        rdc(12'h042, 8'h10);
        wr(12'h03f, 8'h00);
        chk("lr1", 16'h0, {15'h0, low_rate_enable_first_out});
        wr(12'h040, 8'hff);
        rdc(12'h040, 8'h00);
        rdc(12'h03f, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rstn_in = 1'b0;
        spi_sen_n_in = 1'b1;
        spi_sclk_in = 1'b0;
        spi_sdi_in = 1'b0;
        timing_ref_pin_in = 1'b0;
        sync_n_pin_in = 1'b1;
        tk(6);
        rstn_in = 1'b1;
        tk(3);
        t_reset();
        t_delay();
        t_swing();
        t_source();
        t_sync();
        t_low_rate();
        wr(12'h03c, 8'h42);
        // Second reset with fields set
        rstn_in = 1'b0;
        tk(6);
        rstn_in = 1'b1;
        tk(3);
        t_reset();
        close_out();
    end
endmodule // slc_regs_top_tb
bind slc_regs_top slc_regs_asserts slc_regs_asserts_inst (.clk_sys_in, .rstn_in, .spi_sen_n_in,
    .timing_ref_pin_in, .sync_n_pin_in, .timing_ref_out, .sync_n_out, .timing_ref_delay_on_out,
    .timing_ref_delay_step_out, .timing_ref_delay_ps_out, .lane_amplitude_code_out,
    .lane_amplitude_mv_out, .low_rate_enable_first_out, .low_rate_enable_second_out);
`default_nettype wire
